// ---- src/mpu_port_pkg.sv ----
// shared constants for the lcd driver microprocessor port
package mpu_port_pkg;
  localparam int DATA_W = 8;
  localparam int SER_DATA_BIT = 7;
  localparam int SER_CLK_BIT = 6;
  localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
  localparam logic [2:0] SER_COUNT_LAST = 3'h7;
  localparam logic [2:0] SER_COUNT_RESET = 3'h0;
  // display ram geometry: one bit per panel dot
  localparam int RAM_COLS = 132;
  localparam int RAM_PAGES = 9;
  localparam int RAM_ADDR_W = 11;
  // host bus phase length in core clocks (one phase = 3 x 20 ns)
  localparam logic [3:0] PHASE_CYCLES = 4'h3;
  typedef enum logic {BUS_80 = 1'b0, BUS_68 = 1'b1} bus_style_t;
endpackage

// ---- src/mpu_port_if.sv ----
// pin-level carrier between host and lcd driver port
`timescale 1ns/1ps
`default_nettype none
interface mpu_port_if;
  logic bus_style_select;
  logic parallel_select;
  logic reset_in_low;
  logic chip_select_low;
  logic chip_select_high;
  logic data_command_qualifier;
  logic read_strobe;
  logic write_strobe;
  logic [7:0] host_data_out;
  logic [7:0] host_data_oe;
  logic [7:0] dev_data_out;
  logic [7:0] dev_data_oe;
  modport device (
    input bus_style_select, parallel_select, reset_in_low,
    input chip_select_low, chip_select_high, data_command_qualifier,
    input read_strobe, write_strobe, host_data_out, host_data_oe,
    output dev_data_out, dev_data_oe
  );
  modport host (
    output bus_style_select, parallel_select, reset_in_low,
    output chip_select_low, chip_select_high, data_command_qualifier,
    output read_strobe, write_strobe, host_data_out, host_data_oe,
    input dev_data_out, dev_data_oe
  );
endinterface
`default_nettype wire

// ---- src/lcd_port_device.sv ----
// lcd driver end of the microprocessor port
`timescale 1ns/1ps
`default_nettype none
module lcd_port_device (
  input wire logic core_clk,
  input wire logic srst,
  mpu_port_if.device bus,
  output logic cmd_valid,
  output logic [mpu_port_pkg::DATA_W-1:0] cmd_byte,
  output logic data_valid,
  output logic [mpu_port_pkg::DATA_W-1:0] data_byte,
  input wire logic [mpu_port_pkg::RAM_ADDR_W-1:0] dot_addr,
  output logic [mpu_port_pkg::DATA_W-1:0] dot_column,
  output logic in_reset
);
  import mpu_port_pkg::*;

  logic [DATA_W-1:0] ram [0:RAM_COLS*RAM_PAGES-1];
  logic [RAM_ADDR_W-1:0] wr_addr;
  logic selected;
  logic is_68;
  logic enable_prev;
  logic write_prev;
  logic ser_clk_prev;
  logic [2:0] ser_count;
  logic [DATA_W-1:0] ser_shift;
  logic par_take;
  logic ser_take;
  logic [DATA_W-1:0] take_byte;
  logic reading;
  logic [DATA_W-1:0] read_byte;

  ////////////////////////////////////////////////////////////////////////
  assign selected = !bus.chip_select_low && bus.chip_select_high;
  assign is_68 = (bus.bus_style_select == BUS_68);

  // parallel capture edges; all pins taken as synchronous
  always_comb begin
    par_take = 1'b0;
    if (bus.parallel_select && selected && bus.reset_in_low) begin
      if (is_68) begin
        // enable falls while direction is low
        par_take = enable_prev && !bus.read_strobe && !bus.write_strobe;
      end else begin
        par_take = !write_prev && bus.write_strobe;
      end
    end
  end

  assign ser_take = !bus.parallel_select && selected && bus.reset_in_low
    && !ser_clk_prev && bus.host_data_out[SER_CLK_BIT]
    && (ser_count == SER_COUNT_LAST);
  assign take_byte = bus.parallel_select ? bus.host_data_out
    : {ser_shift[DATA_W-2:0], bus.host_data_out[SER_DATA_BIT]};

  always_ff @(posedge core_clk) begin
    if (srst) begin
      enable_prev <= 1'b0;
      write_prev <= 1'b1;
      ser_clk_prev <= 1'b1;
    end else begin
      enable_prev <= bus.read_strobe;
      write_prev <= bus.write_strobe;
      ser_clk_prev <= bus.host_data_out[SER_CLK_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // serial shifter, msb first on serial clock rising edge
  always_ff @(posedge core_clk) begin
    if (srst || !bus.reset_in_low || !selected || bus.parallel_select) begin
      ser_count <= SER_COUNT_RESET;
      ser_shift <= DATA_RESET;
    end else if (!ser_clk_prev && bus.host_data_out[SER_CLK_BIT]) begin
      ser_count <= ser_count + 3'h1;
      ser_shift <= {ser_shift[DATA_W-2:0], bus.host_data_out[SER_DATA_BIT]};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk) begin
    if (srst || !bus.reset_in_low) begin
      cmd_valid <= 1'b0;
      data_valid <= 1'b0;
      cmd_byte <= DATA_RESET;
      data_byte <= DATA_RESET;
    end else begin
      cmd_valid <= (par_take || ser_take) && !bus.data_command_qualifier;
      data_valid <= (par_take || ser_take) && bus.data_command_qualifier;
      if ((par_take || ser_take) && !bus.data_command_qualifier) begin
        cmd_byte <= take_byte;
      end
      if ((par_take || ser_take) && bus.data_command_qualifier) begin
        data_byte <= take_byte;
      end
    end
  end

  // display data fills the ram sequentially; the command decoder
  // that would move the pointer lies outside this port
  always_ff @(posedge core_clk) begin
    if (srst || !bus.reset_in_low) begin
      wr_addr <= '0;
    end else if ((par_take || ser_take) && bus.data_command_qualifier) begin
      ram[wr_addr] <= take_byte;
      if (wr_addr == RAM_ADDR_W'(RAM_COLS*RAM_PAGES-1)) begin
        wr_addr <= '0;
      end else begin
        wr_addr <= wr_addr + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    dot_column <= ram[dot_addr];
    read_byte <= ram[wr_addr];
    in_reset <= srst || !bus.reset_in_low;
  end

  ////////////////////////////////////////////////////////////////////////
  // serial mode is write only, so no read path there
  assign reading = bus.parallel_select && selected && bus.reset_in_low
    && (is_68 ? (bus.read_strobe && bus.write_strobe)
              : !bus.read_strobe);
  assign bus.dev_data_oe = reading ? 8'hFF : 8'h00;
  assign bus.dev_data_out = read_byte;
endmodule
`default_nettype wire

// ---- src/lcd_port_host.sv ----
// microprocessor end of the lcd driver port
`timescale 1ns/1ps
`default_nettype none
module lcd_port_host (
  input wire logic core_clk,
  input wire logic srst,
  mpu_port_if.host bus,
  input wire logic use_68,
  input wire logic use_serial,
  input wire logic hold_reset,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_display,
  input wire logic [mpu_port_pkg::DATA_W-1:0] req_byte,
  output logic req_ready,
  output logic rsp_valid,
  output logic [mpu_port_pkg::DATA_W-1:0] rsp_byte
);
  import mpu_port_pkg::*;

  typedef enum {IDLE, SETUP, STROBE, HOLD, SER_LOW, SER_HIGH} hstate_t;
  hstate_t state;
  logic [3:0] phase;
  logic [2:0] bit_idx;
  logic write_op;
  logic [DATA_W-1:0] shift;

  assign req_ready = (state == IDLE);

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state <= IDLE;
      phase <= 4'h0;
      bit_idx <= 3'h0;
      write_op <= 1'b0;
      shift <= DATA_RESET;
      rsp_valid <= 1'b0;
      rsp_byte <= DATA_RESET;
    end else begin
      rsp_valid <= 1'b0;
      phase <= (phase == PHASE_CYCLES - 4'h1) ? 4'h0 : phase + 4'h1;
      unique case (state)
        IDLE: begin
          phase <= 4'h0;
          if (req_valid) begin
            write_op <= req_write || use_serial;
            shift <= req_byte;
            bit_idx <= 3'h0;
            state <= use_serial ? SER_LOW : SETUP;
          end
        end
        SETUP: if (phase == PHASE_CYCLES - 4'h1) state <= STROBE;
        STROBE: if (phase == PHASE_CYCLES - 4'h1) begin
          state <= HOLD;
          if (!write_op) begin
            rsp_byte <= bus.dev_data_out;
            rsp_valid <= 1'b1;
          end
        end
        HOLD: if (phase == PHASE_CYCLES - 4'h1) state <= IDLE;
        SER_LOW: if (phase == PHASE_CYCLES - 4'h1) state <= SER_HIGH;
        SER_HIGH: if (phase == PHASE_CYCLES - 4'h1) begin
          shift <= {shift[DATA_W-2:0], 1'b0};
          bit_idx <= bit_idx + 3'h1;
          state <= (bit_idx == SER_COUNT_LAST) ? HOLD : SER_LOW;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    bus.bus_style_select = use_68 ? BUS_68 : BUS_80;
    bus.parallel_select = !use_serial;
    bus.reset_in_low = !hold_reset;
    bus.chip_select_low = (state == IDLE);
    bus.chip_select_high = (state != IDLE);
    bus.data_command_qualifier = req_display;
    bus.host_data_out = shift;
    bus.host_data_oe = 8'h00;
    bus.read_strobe = !use_68;
    bus.write_strobe = !use_68;
    if (use_serial) begin
      // only D7 and D6 carry anything in serial mode
      bus.host_data_out = 8'h00;
      bus.host_data_out[SER_DATA_BIT] = shift[DATA_W-1];
      bus.host_data_out[SER_CLK_BIT] = (state == SER_HIGH);
      bus.host_data_oe = (state != IDLE) ? 8'hC0 : 8'h00;
    end else if (state != IDLE) begin
      bus.host_data_oe = write_op ? 8'hFF : 8'h00;
      if (use_68) begin
        bus.write_strobe = !write_op;
        bus.read_strobe = (state == STROBE);
      end else begin
        bus.write_strobe = !(write_op && state == STROBE);
        bus.read_strobe = !(!write_op && state == STROBE);
      end
    end
  end
endmodule
`default_nettype wire

// ---- tb/lcd_port_monitor.sv ----
// pin-level checker for the lcd port pair
`timescale 1ns/1ps
`default_nettype none
module lcd_port_monitor (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic bus_style_select,
  input wire logic parallel_select,
  input wire logic reset_in_low,
  input wire logic chip_select_low,
  input wire logic chip_select_high,
  input wire logic read_strobe,
  input wire logic write_strobe,
  input wire logic [7:0] host_data_oe,
  input wire logic [7:0] dev_data_oe
);
  logic sel;
  logic par;
  assign sel = !chip_select_low && chip_select_high;
  assign par = parallel_select && sel;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  ////////////////////////////////////////////////////////////////////////////
  a_desel_float: assert property (
    !sel |-> dev_data_oe == 8'h00) else $error("driven while deselected");
  a_serial_float: assert property (
    !parallel_select |-> dev_data_oe == 8'h00) else $error("serial drive");
  a_reset_float: assert property (
    !reset_in_low |-> dev_data_oe == 8'h00) else $error("drive in reset");
  a_no_contention: assert property (
    (dev_data_oe & host_data_oe) == 8'h00) else $error("bus contention");
  a_read80_only: assert property (
    !bus_style_select && dev_data_oe != 8'h00 |-> !read_strobe && write_strobe)
    else $error("80 drive without read strobe");
  a_read68_only: assert property (
    bus_style_select && dev_data_oe != 8'h00 |-> read_strobe && write_strobe)
    else $error("68 drive without enable");
  a_write80_data: assert property (
    !bus_style_select && par && $rose(write_strobe) |-> host_data_oe == 8'hFF)
    else $error("80 write edge without data");
  a_write68_data: assert property (
    bus_style_select && par && $fell(read_strobe) && !write_strobe
    |-> host_data_oe == 8'hFF) else $error("68 write edge without data");
  // covers: 80 read, 68 read, serial transfer
  c_read80: cover property (!bus_style_select && dev_data_oe == 8'hFF);
  c_read68: cover property (bus_style_select && dev_data_oe == 8'hFF);
  c_serial: cover property (!parallel_select && sel);
endmodule
`default_nettype wire

// ---- tb/test_lcd_driver_mpu_host_port.sv ----
// self-checking bench for the lcd port pair
`timescale 1ns/1ps
`default_nettype none
module test_lcd_driver_mpu_host_port;
  import mpu_port_pkg::*;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic use_68 = 1'b0, use_serial = 1'b0, hold_reset = 1'b0;
  logic req_valid = 1'b0, req_write = 1'b0, req_display = 1'b0;
  logic [DATA_W-1:0] req_byte = 8'h00;
  logic [RAM_ADDR_W-1:0] dot_addr = 11'h000;
  logic req_ready, rsp_valid, cmd_valid, data_valid, in_reset;
  logic [DATA_W-1:0] rsp_byte, cmd_byte, data_byte, dot_column;
  int miscompares = 0;
  int n_checks = 0;
  always #10 core_clk = ~core_clk;
  mpu_port_if bus ();
  lcd_port_host u_lcd_port_host (.core_clk(core_clk), .srst(srst),
    .bus(bus), .use_68(use_68), .use_serial(use_serial),
    .hold_reset(hold_reset), .req_valid(req_valid), .req_write(req_write),
    .req_display(req_display), .req_byte(req_byte), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_byte(rsp_byte));
  lcd_port_device u_lcd_port_device (.core_clk(core_clk), .srst(srst),
    .bus(bus), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
    .data_valid(data_valid), .data_byte(data_byte), .dot_addr(dot_addr),
    .dot_column(dot_column), .in_reset(in_reset));
  lcd_port_monitor u_lcd_port_monitor (.core_clk(core_clk), .srst(srst),
    .bus_style_select(bus.bus_style_select),
    .parallel_select(bus.parallel_select), .reset_in_low(bus.reset_in_low),
    .chip_select_low(bus.chip_select_low),
    .chip_select_high(bus.chip_select_high),
    .read_strobe(bus.read_strobe), .write_strobe(bus.write_strobe),
    .host_data_oe(bus.host_data_oe), .dev_data_oe(bus.dev_data_oe));
  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    if (miscompares == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // one host transfer; waits bounded, so a stuck port ends the run
  // the qualifier reaches the pins directly, so it only moves while idle
  task automatic op(input logic w, input logic d, input logic [7:0] b);
    int i;
    int j;
    @(negedge core_clk);
    for (i = 0; i < 200 && req_ready !== 1'b1; i++) @(negedge core_clk);
    @(posedge core_clk);
    req_write <= w;
    req_display <= d;
    req_byte <= b;
    req_valid <= 1'b1;
    @(posedge core_clk);
    req_valid <= 1'b0;
    @(negedge core_clk);
    for (j = 0; j < 200 && (w ? (d ? data_valid : cmd_valid) : rsp_valid)
         !== 1'b1; j++) @(negedge core_clk);
    if (i == 200 || j == 200) begin
      miscompares++;
      finish_test();
    end else begin
      check({6'h00, cmd_valid, data_valid}, {6'h00, w & ~d, w & d});
      if (w) check(d ? data_byte : cmd_byte, b);
      else check(rsp_byte, b);
    end
  endtask
  // srst also rewinds the ram write pointer to zero
  task automatic run(input logic m, input logic s);
    int k;
    @(posedge core_clk);
    srst <= 1'b1;
    use_68 <= m;
    use_serial <= s;
    repeat (5) @(posedge core_clk);
    srst <= 1'b0;
    op(1'b1, 1'b0, 8'hA5);
    op(1'b1, 1'b1, 8'h3C);
    if (!s) begin
      // fill the rest of the ram so the pointer wraps back onto the 3C
      for (k = 1; k < RAM_COLS * RAM_PAGES; k++) begin
        op(1'b1, 1'b1, 8'(k));
      end
      op(1'b0, 1'b1, 8'h3C);
    end
    @(posedge core_clk);
    dot_addr <= 11'h000;
    repeat (2) @(negedge core_clk);
    check(dot_column, 8'h3C);
  endtask
  initial begin
    run(1'b0, 1'b0);
    run(1'b1, 1'b0);
    run(1'b0, 1'b1);
    @(posedge core_clk);
    hold_reset <= 1'b1;
    repeat (4) @(negedge core_clk);
    check({7'h00, in_reset}, 8'h01);
    @(posedge core_clk);
    hold_reset <= 1'b0;
    repeat (4) @(negedge core_clk);
    check({7'h00, in_reset}, 8'h00);
    finish_test();
  end
endmodule
`default_nettype wire
